// ---- core/gpbk_bank.sv ----
// GPIO port bank: six ports with direction, pull-up and function-select control,
// open-drain on ports 0, 1, 2 and 4, pin debounce and port 0 change interrupts.
// Assumes pads resolve level from out/oe/pu and pad inputs are asynchronous.
//
// Function
// - Direction bit 0 input, 1 output.
// - Output drives data; input reads pin level.
// - Pull-up select bit connects pull-up resistor.
// - Reset clears all pull-up select bits.
// - Open-drain bit: 0 push-pull, 1 open-drain.
// - Reset clears function selects to zero.
// - Debounce only on listed port 0/1/5 pins.
// - Port 0 debounce bits enable pins 7..2.
// - Port 0 input pins interrupt on state change.
// - Port 0 eight bits in every register.
// - Control registers 8-bit, read/write, reset zero; function select 5 shares EF, which reads back function select 4.
// - Filter rejects levels not seen thrice running.
// - Stop mode bypasses debounce, keeping its settings.
// - Port 0 debounce clock serves ports 1, 5.
`timescale 1ns/10ps

module gpbk_bank #(
	parameter int DB_SLOW_DIV = gpbk_pkg::DB_DIV_SLOW
) (
	input  wire logic                 clk_i,      // System clock, 200 MHz
	input  wire logic                 rst_i,      // Asynchronous reset, active high
	input  wire gpbk_pkg::gpbk_bus_s  bus_i,      // Register bus request
	output logic [7:0]                rdata_o,    // Read data, cycle after read strobe
	input  wire gpbk_pkg::gpbk_port_t pad_in_i,   // Pin levels, asynchronous
	output gpbk_pkg::gpbk_pad_s       pad_o,      // Pin drive, enable and pull-up
	output logic [gpbk_pkg::NUM_FSEL-1:0][7:0] fsel_o, // Function select values
	input  wire logic                 stop_mode_i, // Stop mode, same clock domain
	output logic                      irq_o       // Level interrupt
);

	// Returns the first register index at an address, or NUM_REGS if unmapped
	function automatic int reg_index(input logic [7:0] addr);
		reg_index = gpbk_pkg::NUM_REGS;
		for (int i = gpbk_pkg::NUM_REGS - 1; i >= 0; i--) begin
			if (addr == gpbk_pkg::REG_ADDR[i]) begin
				reg_index = i;
			end
		end
	endfunction

	// Maps the two debounce enable registers onto pin positions
	function automatic gpbk_pkg::gpbk_port_t db_map(input logic [7:0] port0_debounce_control,
	                                                 input logic [7:0] port1_port5_debounce_enable);
		db_map       = '0;
		db_map[0][7:2] = port0_debounce_control[5:0];
		db_map[1][1] = port1_port5_debounce_enable[0];
		db_map[1][2] = port1_port5_debounce_enable[1];
		db_map[1][6] = port1_port5_debounce_enable[2];
		db_map[1][7] = port1_port5_debounce_enable[3];
		db_map[5][2] = port1_port5_debounce_enable[4];
		db_map[5][4] = port1_port5_debounce_enable[5];
	endfunction

	logic [7:0]            regs_q [gpbk_pkg::NUM_REGS];
	logic [7:0]            regs_d [gpbk_pkg::NUM_REGS];
	gpbk_pkg::gpbk_port_t  meta_q;
	gpbk_pkg::gpbk_port_t  sync2_q;
	gpbk_pkg::gpbk_port_t  sync3_q;
	gpbk_pkg::gpbk_port_t  stable_q;
	gpbk_pkg::gpbk_port_t  samp_a_q;
	gpbk_pkg::gpbk_port_t  samp_b_q;
	gpbk_pkg::gpbk_port_t  samp_c_q;
	gpbk_pkg::gpbk_port_t  filt_q;
	logic [7:0]            lvl0_prev_q;
	logic [gpbk_pkg::DB_CNT_W-1:0] div_cnt_q;
	logic                  tick_q;
	logic [7:0]            rdata_q;
	gpbk_pkg::gpbk_pad_s   pad_q;
	logic                  irq_q;

	gpbk_pkg::gpbk_port_t  data_v;
	gpbk_pkg::gpbk_port_t  dir_v;
	gpbk_pkg::gpbk_port_t  pu_v;
	gpbk_pkg::gpbk_port_t  od_v;
	gpbk_pkg::gpbk_port_t  db_en;
	gpbk_pkg::gpbk_port_t  level;
	gpbk_pkg::gpbk_port_t  stable_d;
	gpbk_pkg::gpbk_port_t  filt_d;
	gpbk_pkg::gpbk_pad_s   pad_d;
	gpbk_pkg::gpbk_debounce_clock_select_e debounce_clock_select_sel;
	logic [7:0]            chg_evt;
	logic                  tick_d;
	logic                  slow_wrap;
	int                    wr_idx;
	int                    rd_idx;
	logic [7:0]            rd_val;

	// Register views per port
	genvar gp;
	generate
		for (gp = 0; gp < gpbk_pkg::NUM_PORTS; gp++) begin : g_port
			assign data_v[gp] = regs_q[gpbk_pkg::IDX_DATA + gp];
			assign dir_v[gp]  = regs_q[gpbk_pkg::IDX_DIR + gp];
			assign pu_v[gp]   = regs_q[gpbk_pkg::IDX_PU + gp];
			assign od_v[gp]   = gpbk_pkg::OD_HAS[gp] ?
			                    regs_q[gpbk_pkg::OD_IDX[gp]] : 8'h00;

			// Input level seen by software and the change detector
			assign level[gp] = (db_en[gp] & filt_q[gp]) |
			                   (~db_en[gp] & stable_q[gp]);

			// Push-pull drives data; open-drain only ever pulls low
			assign pad_d.out[gp] = data_v[gp] & ~od_v[gp] &
			                       gpbk_pkg::PORT_MASK[gp];
			assign pad_d.oe[gp]  = dir_v[gp] & (~od_v[gp] | ~data_v[gp]) &
			                       gpbk_pkg::PORT_MASK[gp];
			assign pad_d.pu[gp]  = pu_v[gp] & gpbk_pkg::PORT_MASK[gp];
		end
	endgenerate

	// Debounce is bypassed in stop mode; the enable bits themselves survive
	assign db_en = stop_mode_i ? '0 :
	               db_map(regs_q[gpbk_pkg::IDX_DB0],
	                      regs_q[gpbk_pkg::IDX_DB15]);

	// A synchronised change counts once the second and third stages agree
	assign stable_d = (sync2_q & sync3_q) | (stable_q & (sync2_q ^ sync3_q));

	// Filter output moves only after three equal samples in a row
	assign filt_d = (samp_a_q & samp_b_q & samp_c_q) |
	                (filt_q & (samp_a_q | samp_b_q | samp_c_q));

	// One sampling clock drives the filters of ports 0, 1 and 5
	assign debounce_clock_select_sel = gpbk_pkg::gpbk_debounce_clock_select_e'(regs_q[gpbk_pkg::IDX_DB0]
	                   [gpbk_pkg::DEBOUNCE_CLOCK_SELECT_LSB +: gpbk_pkg::DEBOUNCE_CLOCK_SELECT_W]);
	assign slow_wrap = (div_cnt_q == gpbk_pkg::DB_CNT_W'(DB_SLOW_DIV - 1));
	assign tick_d    = (debounce_clock_select_sel == gpbk_pkg::DEBOUNCE_CLOCK_SELECT_DIV1) ? 1'b1 :
	                   (debounce_clock_select_sel == gpbk_pkg::DEBOUNCE_CLOCK_SELECT_DIV4) ?
	                   (div_cnt_q[1:0] == 2'(gpbk_pkg::DB_DIV_MID - 1)) :
	                   (debounce_clock_select_sel == gpbk_pkg::DEBOUNCE_CLOCK_SELECT_DIV4096) ? slow_wrap :
	                   1'b0;

	// Port 0 change events, only on pins set as inputs
	assign chg_evt = (level[0] ^ lvl0_prev_q) & ~dir_v[0];

	assign wr_idx = bus_i.wr ? reg_index(bus_i.addr) : gpbk_pkg::NUM_REGS;
	assign rd_idx = reg_index(bus_i.addr);

	// Data registers read back the pin on inputs and the latch on outputs
	always_comb begin
		rd_val = 8'h00;
		if (rd_idx < gpbk_pkg::IDX_DIR) begin
			rd_val = ((dir_v[rd_idx] & data_v[rd_idx]) |
			          (~dir_v[rd_idx] & level[rd_idx])) &
			         gpbk_pkg::PORT_MASK[rd_idx];
		end else if (rd_idx < gpbk_pkg::NUM_REGS) begin
			rd_val = regs_q[rd_idx];
		end
	end

	// Next register values; a shared address writes every register behind it
	always_comb begin
		for (int i = 0; i < gpbk_pkg::NUM_REGS; i++) begin
			regs_d[i] = regs_q[i];
			if (bus_i.wr && bus_i.addr == gpbk_pkg::REG_ADDR[i] &&
			    i != gpbk_pkg::IDX_IST) begin
				regs_d[i] = bus_i.wdata & gpbk_pkg::REG_MASK[i];
			end
		end
		// Write one clears; a same-cycle event wins over the clear
		regs_d[gpbk_pkg::IDX_IST] = (regs_q[gpbk_pkg::IDX_IST] &
		                             ~((wr_idx == gpbk_pkg::IDX_IST) ?
		                               bus_i.wdata : 8'h00)) | chg_evt;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < gpbk_pkg::NUM_REGS; i++) begin
				regs_q[i] <= gpbk_pkg::RST_VAL;
			end
		end else begin
			for (int i = 0; i < gpbk_pkg::NUM_REGS; i++) begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	// Pin synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q   <= '0;
			sync2_q  <= '0;
			sync3_q  <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= pad_in_i;
			sync2_q  <= meta_q;
			sync3_q  <= sync2_q;
			stable_q <= stable_d;
		end
	end

	// Sampling divider and debounce shift chain
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_q <= '0;
			tick_q    <= 1'b0;
			samp_a_q  <= '0;
			samp_b_q  <= '0;
			samp_c_q  <= '0;
			filt_q    <= '0;
		end else begin
			div_cnt_q <= slow_wrap ? '0 : div_cnt_q + 1'b1;
			tick_q    <= tick_d;
			filt_q    <= filt_d;
			if (tick_q) begin
				samp_a_q <= stable_q;
				samp_b_q <= samp_a_q;
				samp_c_q <= samp_b_q;
			end
		end
	end

	// Outputs are registered copies of the decoded state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lvl0_prev_q <= 8'h00;
			rdata_q     <= 8'h00;
			pad_q       <= '0;
			irq_q       <= 1'b0;
		end else begin
			lvl0_prev_q <= level[0];
			rdata_q     <= bus_i.rd ? rd_val : 8'h00;
			pad_q       <= pad_d;
			irq_q       <= |(regs_q[gpbk_pkg::IDX_IST] & regs_q[gpbk_pkg::IDX_IMSK]);
		end
	end

	generate
		for (gp = 0; gp < gpbk_pkg::NUM_FSEL; gp++) begin : g_fsel
			assign fsel_o[gp] = regs_q[gpbk_pkg::IDX_FSEL + gp];
		end
	endgenerate

	assign rdata_o = rdata_q;
	assign pad_o   = pad_q;
	assign irq_o   = irq_q;

endmodule

// ---- core/gpbk_pkg.sv ----
// Constants, field layouts and carrier types for the GPIO port bank.
// Assumes an 8-bit register address space reached over a plain strobe port.
package gpbk_pkg;

	localparam int NUM_PORTS = 6;
	localparam int NUM_REGS  = 35;
	localparam int NUM_FSEL  = 9;

	// Register file index layout
	localparam int IDX_DATA = 0;
	localparam int IDX_DIR  = 6;
	localparam int IDX_PU   = 12;
	localparam int IDX_OD   = 18;
	localparam int IDX_FSEL = 22;
	localparam int IDX_DB0  = 31;
	localparam int IDX_DB15 = 32;
	localparam int IDX_IST  = 33;
	localparam int IDX_IMSK = 34;

	localparam logic [7:0] RST_VAL = 8'h00;

	// Byte addresses, in index order
	localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
		8'h80, 8'h88, 8'h90, 8'h98, 8'hA0, 8'hB0,   // port data 0..5
		8'hA1, 8'hB1, 8'hB9, 8'hC1, 8'hC9, 8'hD1,   // direction 0..5
		8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hA3, 8'h95,   // pull-up select 0..5
		8'h91, 8'h92, 8'h93, 8'h94,                 // open-drain 0,1,2,4
		8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7,   // function select 0L..2H
		8'hEE, 8'hEF, 8'hEF,                        // function select 3,4,5
		8'hDE, 8'hDF,                               // debounce control/enable
		8'hF9, 8'hCA                                // interrupt status, mask
	};

	// Implemented bits per register; the rest read as zero
	localparam logic [7:0] REG_MASK [NUM_REGS] = '{
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F,
		8'hFF, 8'hFF, 8'hFF, 8'h0F,
		8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'h0F,
		8'hFF, 8'h7F, 8'h3F,
		8'hFF, 8'h3F,
		8'hFF, 8'hFF
	};

	localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F
	};

	// Open-drain register index per port, zero where the port has none
	localparam int OD_IDX [NUM_PORTS] = '{18, 19, 20, 0, 21, 0};
	localparam logic   OD_HAS [NUM_PORTS] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	// Debounce control field layout
	localparam int DEBOUNCE_CLOCK_SELECT_LSB = 6;
	localparam int DEBOUNCE_CLOCK_SELECT_W   = 2;

	// Debounce sampling divisors of the system clock
	localparam int DB_DIV_MID  = 4;
	localparam int DB_DIV_SLOW = 4096;
	localparam int DB_CNT_W    = 12;

	typedef enum logic [DEBOUNCE_CLOCK_SELECT_W-1:0] {
		DEBOUNCE_CLOCK_SELECT_DIV1,
		DEBOUNCE_CLOCK_SELECT_DIV4,
		DEBOUNCE_CLOCK_SELECT_DIV4096,
		DEBOUNCE_CLOCK_SELECT_RSVD
	} gpbk_debounce_clock_select_e;

	typedef logic [NUM_PORTS-1:0][7:0] gpbk_port_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gpbk_bus_s;

	typedef struct packed {
		gpbk_port_t out;
		gpbk_port_t oe;
		gpbk_port_t pu;
	} gpbk_pad_s;

endpackage

// ---- verification/gpbk_chk.sv ----
// Checker for the GPIO port bank, bound to the bank's ports.
// Assumes single clock domain and one-cycle bus strobes.
`timescale 1ns/10ps
module gpbk_chk (
	input wire logic                                 clk_i,   // System clock
	input wire logic                                 rst_i,   // Reset, active high
	input wire gpbk_pkg::gpbk_bus_s                  bus_i,   // Register bus request
	input wire logic [7:0]                           rdata_o, // Read data
	input wire gpbk_pkg::gpbk_pad_s                  pad_o,   // Pin drive
	input wire logic [gpbk_pkg::NUM_FSEL-1:0][7:0]   fsel_o,  // Function selects
	input wire logic                                 irq_o    // Level interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read cycle");
	readback_a: assert property (bus_i.wr && bus_i.addr inside {8'hAC, 8'hA1, 8'h91}
		##2 bus_i.rd && bus_i.addr == $past(bus_i.addr, 2)
		|=> rdata_o == $past(bus_i.wdata, 3))
		else $error("register read back differs from write");
	unmapped_a: assert property (bus_i.rd && bus_i.addr == 8'h81 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	pu_follow_a: assert property (bus_i.wr && bus_i.addr == 8'hAC
		|-> ##2 pad_o.pu[0] == $past(bus_i.wdata, 2))
		else $error("pull-up connect does not follow select");
	dir_input_a: assert property (bus_i.wr && bus_i.addr == 8'hA1
		|-> ##2 (pad_o.oe[0] & ~$past(bus_i.wdata, 2)) == 8'h00)
		else $error("input pin driven");
	fsel_follow_a: assert property (bus_i.wr && bus_i.addr == 8'hD2
		|=> fsel_o[0] == ($past(bus_i.wdata) & 8'h7F))
		else $error("function select output wrong");
	mask_irq_a: assert property (bus_i.wr && bus_i.addr == 8'hCA && bus_i.wdata == 8'h00
		|-> ##3 !irq_o)
		else $error("interrupt high with all masked");
	reset_clear_a: assert property ($fell(rst_i)
		|-> pad_o.pu == '0 && fsel_o == '0 && !irq_o)
		else $error("pull-up or function select not cleared by reset");
	port4_width_a: assert property ((pad_o.pu[4][7:4] | pad_o.oe[4][7:4]) == 4'h0)
		else $error("unimplemented port 4 bits active");
endmodule

bind gpbk_bank gpbk_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.pad_o(pad_o), .fsel_o(fsel_o), .irq_o(irq_o));

// ---- verification/gpbk_pads.sv ----
// Pin model: external drivers, pull-ups and floating pins of the bank.
// Assumes the bank's pad drive is registered on clk_i.
`timescale 1ns/10ps
module gpbk_pads (
	input  wire logic                 clk_i,    // System clock
	input  wire gpbk_pkg::gpbk_pad_s  pad_i,    // Device drive, enable, pull-up
	input  wire gpbk_pkg::gpbk_port_t ext_i,    // External drive level
	input  wire gpbk_pkg::gpbk_port_t ext_en_i, // External drive enable
	output gpbk_pkg::gpbk_port_t      pin_o     // Resolved pin level
);
	gpbk_pkg::gpbk_port_t flt_q = '0;

	// A floating pin must not look stable, so it toggles every cycle
	always_ff @(posedge clk_i) begin
		flt_q <= ~flt_q;
	end
	assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_en_i & ext_i)
		| (~pad_i.oe & ~ext_en_i & (pad_i.pu | flt_q));
endmodule

// ---- verification/tb_top.sv ----
// Testbench for the GPIO port bank: bus tasks and directed tests.
// Assumes the pin model resolves pads; slow debounce divisor set to 16.
`timescale 1ns/10ps
module tb_top;
	logic                 clk_i = 0;
	logic                 rst_i = 1;
	logic                 stop = 0;
	gpbk_pkg::gpbk_bus_s  b = '0;
	gpbk_pkg::gpbk_port_t ext = '0;
	gpbk_pkg::gpbk_port_t ext_en = '1;
	gpbk_pkg::gpbk_port_t pin;
	gpbk_pkg::gpbk_pad_s  pad;
	logic [7:0]           rdata;
	logic                 irq;
	int                   n_errors = 0;
	int                   total_checks = 0;
	int                   dv [3] = '{1, 4, 16};

	always #2.5 clk_i = ~clk_i;

	gpbk_bank #(.DB_SLOW_DIV(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(b),
		.rdata_o(rdata), .pad_in_i(pin), .pad_o(pad), .fsel_o(), .stop_mode_i(stop),
		.irq_o(irq));
	gpbk_pads u_pads (.clk_i(clk_i), .pad_i(pad), .ext_i(ext), .ext_en_i(ext_en), .pin_o(pin));

	task chk(input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		b <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		b.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		b <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i);
		b.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		int i;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < gpbk_pkg::NUM_REGS; i++) rd(gpbk_pkg::REG_ADDR[i], 8'h00);
		rd(8'h81, 8'h00);
		for (i = 6; i < 30; i++) begin
			wr(gpbk_pkg::REG_ADDR[i], 8'hFF);
			rd(gpbk_pkg::REG_ADDR[i], gpbk_pkg::REG_MASK[i]);
			wr(gpbk_pkg::REG_ADDR[i], 8'h00);
		end
		$display("registers done");
		wr(8'hA1, 8'hFF);
		wr(8'h80, 8'h5A);
		@(posedge clk_i);
		#1 chk(pad.out[0], 8'h5A);
		chk(pad.oe[0], 8'hFF);
		rd(8'h80, 8'h5A);
		wr(8'h91, 8'hF0);
		@(posedge clk_i);
		#1 chk(pad.oe[0], 8'hAF);
		chk(pad.out[0], 8'h0A);
		wr(8'h91, 8'h00);
		wr(8'hA1, 8'h00);
		ext[0] <= 8'h3C;
		repeat (8) @(posedge clk_i);
		rd(8'h80, 8'h3C);
		wr(8'hAC, 8'hFF);
		ext_en[0] <= 8'h00;
		repeat (8) @(posedge clk_i);
		chk(pad.pu[0], 8'hFF);
		rd(8'h80, 8'hFF);
		ext <= '0;
		ext_en <= '1;
		wr(8'hAC, 8'h00);
		$display("pins done");
		// Let the pin fall from the pull-up test reach the status bits before clearing
		repeat (8) @(posedge clk_i);
		wr(8'hF9, 8'hFF);
		wr(8'hCA, 8'h01);
		ext[0][0] <= 1'b1;
		for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk_i);
		chk({7'h00, irq}, 8'h01);
		if (irq !== 1'b1) results();
		rd(8'hF9, 8'h01);
		wr(8'hCA, 8'h00);
		ext[0][0] <= 1'b0;
		repeat (12) @(posedge clk_i);
		chk({7'h00, irq}, 8'h00);
		rd(8'hF9, 8'h01);
		wr(8'hF9, 8'hFF);
		wr(8'hA1, 8'h02);
		wr(8'h80, 8'h02);
		repeat (12) @(posedge clk_i);
		rd(8'hF9, 8'h00);
		wr(8'hA1, 8'h00);
		$display("interrupt done");
		for (i = 0; i < 3; i++) begin
			wr(8'hDE, {i[1:0], 6'h01});
			repeat (6 * dv[i] + 10) @(posedge clk_i);
			wr(8'hF9, 8'hFF);
			ext[0][2] <= 1'b1;
			repeat (2 * dv[i]) @(posedge clk_i);
			ext[0][2] <= 1'b0;
			repeat (6 * dv[i] + 10) @(posedge clk_i);
			rd(8'hF9, 8'h00);
			ext[0][2] <= 1'b1;
			repeat (6 * dv[i] + 10) @(posedge clk_i);
			rd(8'hF9, 8'h04);
			// Next pass must start from a low pin so the short pulse is a real pulse
			ext[0][2] <= 1'b0;
		end
		stop <= 1'b1;
		wr(8'hF9, 8'hFF);
		ext[0][2] <= 1'b0;
		repeat (4) @(posedge clk_i);
		ext[0][2] <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(8'hF9, 8'h04);
		$display("debounce done");
		results();
	end
endmodule
